// ---- design/addr_mode_pkg.sv ----
// address-mode unit constants, types and layouts
// assumes one 250 MHz core clock; a state is one clock cycle
// Functional notes
// - addressing mode comes from the mode-select pins, never from software.
// - this product supports advanced addressing only; normal mode is unavailable.
// - normal mode gives linear access to at most 64 kbytes.
// - normal mode keeps every instruction; only the low 16 effective-address bits count.
// - advanced mode gives linear access to at most 16 Mbytes.
// - normal vector table starts at zero, one 16-bit branch address per entry.
// - advanced vector table starts at zero, 32-bit entries, low 24 bits are target.
// - normal memory-indirect branch reads a 16-bit word between 0x0000 and 0x00FF.
// - advanced memory-indirect branch reads a longword 0x00-0xFF, top byte taken as zero.
// - call pushes program counter; exception pushes counter, flags and extended control.
// - in interrupt control mode 0 exceptions do not push extended control.
// - normal mode: pre-decrement/post-increment carry or borrow also updates upper half.
// - advanced mode: upper half is its own 16-bit register or top of 32 bits; the unit always carries into it.
// - register add and subtract at 8, 16 or 32 bits take one state.
// - unsigned multiply 3 or 4 states, signed multiply 4 or 5 states.
// - divide takes 12 states for 16/8 and 20 states for 32/16.
// - the sleep instruction puts the core into power-down.
// - program counter is 24 bits; its lowest bit reads as zero on fetch.
// ============================================================
// constants
// ============================================================
package addr_mode_pkg;
   // mode pin code that would ask for normal mode
   localparam logic [2:0]  MODE_PINS_NORMAL = 3'h1;
   localparam logic        NORMAL_AVAILABLE = 1'h0;
   localparam logic        ADV_MODE_RESET   = 1'h1;
   localparam logic [31:0] NORMAL_EA_MASK   = 32'h0000FFFF;
   localparam logic [31:0] ADV_EA_MASK      = 32'h00FFFFFF;
   localparam logic [31:0] VEC_BASE_NORMAL  = 32'h00000000;
   localparam logic [31:0] VEC_BASE_ADV     = 32'h00000000;
   localparam logic [31:0] IND_BASE         = 32'h00000000;
   localparam logic [31:0] IND_LIMIT        = 32'h000000FF;
   localparam logic [23:0] PC_ALIGN_MASK    = 24'hFFFFFE;
   // execution states per operation
   localparam logic [4:0]  ADD_STATES       = 5'h01;
   localparam logic [4:0]  MULU_B_STATES    = 5'h03;
   localparam logic [4:0]  MULU_W_STATES    = 5'h04;
   localparam logic [4:0]  MULS_B_STATES    = 5'h04;
   localparam logic [4:0]  MULS_W_STATES    = 5'h05;
   localparam logic [4:0]  DIV_B_STATES     = 5'h0C;
   localparam logic [4:0]  DIV_W_STATES     = 5'h14;
   // push mask bit positions
   localparam int          PUSH_PC_BIT      = 0;
   localparam int          PUSH_FLAGS_BIT   = 1;
   localparam int          PUSH_EXT_BIT     = 2;
   localparam logic [2:0]  PUSH_NONE        = 3'h0;

   typedef enum logic [2:0] {
      OP_ADD,
      OP_MULU_B,
      OP_MULU_W,
      OP_MULS_B,
      OP_MULS_W,
      OP_DIV_B,
      OP_DIV_W
   } op_kind_t;

   typedef enum logic {
      MS_IDLE,
      MS_READ
   } mem_state_t;
endpackage : addr_mode_pkg

// ---- design/cpu_address_mode_logic.sv ----
// address-mode unit of the core: mode capture, address truncation,
// vector and memory-indirect fetch, stack push selection, op timing
// assumes a memory that answers a read with a one-cycle ack, any latency
`timescale 1ns/1ps
`default_nettype none
module cpu_address_mode_logic
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [2:0]  mode_pins_in,
   output logic             adv_mode_out,
   output logic             mode_fault_out,
   input  wire logic        ea_valid_in,
   input  wire logic [31:0] ea_in,
   output logic [31:0]      ea_phys_out,
   input  wire logic [23:0] pc_in,
   output logic [23:0]      fetch_addr_out,
   input  wire logic        vec_req_in,
   input  wire logic [7:0]  vec_num_in,
   input  wire logic        ind_req_in,
   input  wire logic [7:0]  ind_abs_in,
   output logic             fetch_ready_out,
   output logic             mem_rd_out,
   output logic [31:0]      mem_addr_out,
   output logic             mem_long_out,
   input  wire logic        mem_ack_in,
   input  wire logic [31:0] mem_rdata_in,
   output logic             target_valid_out,
   output logic [31:0]      target_out,
   input  wire logic        push_req_in,
   input  wire logic        push_exc_in,
   input  wire logic        int_mode0_in,
   output logic [2:0]       push_items_out,
   input  wire logic        incdec_in,
   input  wire logic        dec_in,
   input  wire logic [2:0]  step_in,
   input  wire logic [15:0] upper_in,
   input  wire logic [15:0] lower_in,
   output logic [15:0]      upper_out,
   output logic [15:0]      lower_out,
   input  wire logic        op_start_in,
   input  wire logic [2:0]  op_kind_in,
   output logic             op_busy_out,
   output logic             op_done_out,
   input  wire logic        sleep_in,
   input  wire logic        wake_in,
   output logic             power_down_out
);

   // ============================================================
   // mode capture
   // ============================================================
   logic        adv_mode_q;
   logic        adv_mode_d;
   logic        mode_fault_q;
   logic        mode_taken_q;
   logic [31:0] ea_mask;

   // pins are caught on the first edge after release, never under reset
   assign adv_mode_d = !((mode_pins_in == addr_mode_pkg::MODE_PINS_NORMAL) &&
                         addr_mode_pkg::NORMAL_AVAILABLE);
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         adv_mode_q   <= addr_mode_pkg::ADV_MODE_RESET;
         mode_fault_q <= 1'h0;
         mode_taken_q <= 1'h0;
      end
      else if (!mode_taken_q)
      begin
         adv_mode_q   <= adv_mode_d;
         mode_fault_q <= (mode_pins_in == addr_mode_pkg::MODE_PINS_NORMAL) &&
                         !addr_mode_pkg::NORMAL_AVAILABLE;
         mode_taken_q <= 1'h1;
      end
   end
   assign adv_mode_out   = adv_mode_q;
   assign mode_fault_out = mode_fault_q;
   // the mode latches once; a pin change later has no effect until reset
   assign ea_mask = adv_mode_q ? addr_mode_pkg::ADV_EA_MASK : addr_mode_pkg::NORMAL_EA_MASK;

   // ============================================================
   // effective address and fetch address
   // ============================================================
   logic [31:0] ea_phys_q;
   logic [23:0] fetch_addr_q;

   // unused upper bits go out as zero rather than as stale high bits
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         ea_phys_q <= 32'h00000000;
      else if (ea_valid_in)
         ea_phys_q <= ea_in & ea_mask;
   end
   assign ea_phys_out = ea_phys_q;

   // instructions are word-sized, so the lowest counter bit is ignored
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         fetch_addr_q <= 24'h000000;
      else
         fetch_addr_q <= pc_in & addr_mode_pkg::PC_ALIGN_MASK;
   end
   assign fetch_addr_out = fetch_addr_q;

   // ============================================================
   // vector and memory-indirect fetch
   // ============================================================
   addr_mode_pkg::mem_state_t ms_q;
   logic        power_down_q;
   logic        mem_long_q;
   logic [31:0] mem_addr_q;
   logic [31:0] target_q;
   logic        target_valid_q;
   logic        fetch_take;
   logic [31:0] vec_addr;
   logic [31:0] ind_addr;

   assign fetch_ready_out = (ms_q == addr_mode_pkg::MS_IDLE) && !power_down_q;
   assign fetch_take      = fetch_ready_out && (vec_req_in || ind_req_in);
   // entries are 2 bytes in normal mode and 4 in advanced mode
   assign vec_addr = adv_mode_q ? addr_mode_pkg::VEC_BASE_ADV + 32'({vec_num_in, 2'h0})
                                : addr_mode_pkg::VEC_BASE_NORMAL + 32'({vec_num_in, 1'h0});
   // the 8-bit field bounds the operand to the first 256 bytes
   assign ind_addr = addr_mode_pkg::IND_BASE + 32'(ind_abs_in);

   // vectors win over indirect branches when both ask at once
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ms_q       <= addr_mode_pkg::MS_IDLE;
         mem_addr_q <= 32'h00000000;
         mem_long_q <= 1'h0;
      end
      else
      begin
         unique case (ms_q)
            addr_mode_pkg::MS_IDLE:
            begin
               if (fetch_take)
               begin
                  mem_addr_q <= vec_req_in ? vec_addr : ind_addr;
                  mem_long_q <= adv_mode_q;
                  ms_q       <= addr_mode_pkg::MS_READ;
               end
            end
            addr_mode_pkg::MS_READ:
            begin
               if (mem_ack_in)
                  ms_q <= addr_mode_pkg::MS_IDLE;
            end
         endcase
      end
   end
   assign mem_rd_out   = (ms_q == addr_mode_pkg::MS_READ);
   assign mem_addr_out = mem_addr_q;
   assign mem_long_out = mem_long_q;

   // the reserved top byte is dropped, never trusted from memory
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         target_q       <= 32'h00000000;
         target_valid_q <= 1'h0;
      end
      else
      begin
         target_valid_q <= mem_rd_out && mem_ack_in;
         if (mem_rd_out && mem_ack_in)
            target_q <= mem_rdata_in & ea_mask;
      end
   end
   assign target_valid_out = target_valid_q;
   assign target_out       = target_q;

   // ============================================================
   // stack push selection
   // ============================================================
   logic [2:0] push_items_q;

   // one-cycle mask naming what the stack sequencer must push
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         push_items_q <= addr_mode_pkg::PUSH_NONE;
      else
      begin
         push_items_q <= addr_mode_pkg::PUSH_NONE;
         if (push_req_in)
         begin
            push_items_q[addr_mode_pkg::PUSH_PC_BIT]    <= 1'h1;
            push_items_q[addr_mode_pkg::PUSH_FLAGS_BIT] <= push_exc_in;
            push_items_q[addr_mode_pkg::PUSH_EXT_BIT]   <= push_exc_in && !int_mode0_in;
         end
      end
   end
   assign push_items_out = push_items_q;

   // ============================================================
   // upper/lower half update for post-increment and pre-decrement
   // ============================================================
   logic [31:0] pair_sum;
   logic [15:0] upper_q;
   logic [15:0] lower_q;

   // carry always ripples into the upper half, whatever it held
   assign pair_sum = dec_in ? {upper_in, lower_in} - 32'(step_in)
                            : {upper_in, lower_in} + 32'(step_in);
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         upper_q <= 16'h0000;
         lower_q <= 16'h0000;
      end
      else if (incdec_in)
      begin
         upper_q <= pair_sum[31:16];
         lower_q <= pair_sum[15:0];
      end
   end
   assign upper_out = upper_q;
   assign lower_out = lower_q;

   // ============================================================
   // arithmetic timing
   // ============================================================
   logic [4:0] op_cnt_q;
   logic [4:0] op_states;
   logic       op_take;

   always_comb
   begin
      unique case (op_kind_in)
         addr_mode_pkg::OP_ADD:    op_states = addr_mode_pkg::ADD_STATES;
         addr_mode_pkg::OP_MULU_B: op_states = addr_mode_pkg::MULU_B_STATES;
         addr_mode_pkg::OP_MULU_W: op_states = addr_mode_pkg::MULU_W_STATES;
         addr_mode_pkg::OP_MULS_B: op_states = addr_mode_pkg::MULS_B_STATES;
         addr_mode_pkg::OP_MULS_W: op_states = addr_mode_pkg::MULS_W_STATES;
         addr_mode_pkg::OP_DIV_B:  op_states = addr_mode_pkg::DIV_B_STATES;
         addr_mode_pkg::OP_DIV_W:  op_states = addr_mode_pkg::DIV_W_STATES;
         default:                  op_states = addr_mode_pkg::ADD_STATES;
      endcase
   end

   // a start while busy or asleep is ignored, not queued
   assign op_take = op_start_in && (op_cnt_q == 5'h00) && !power_down_q;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         op_cnt_q <= 5'h00;
      else if (op_take)
         op_cnt_q <= op_states;
      else if (op_cnt_q != 5'h00)
         op_cnt_q <= op_cnt_q - 5'h01;
   end
   assign op_busy_out = (op_cnt_q != 5'h00);
   assign op_done_out = (op_cnt_q == 5'h01);

   // ============================================================
   // power-down
   // ============================================================
   // sleep holds off new fetches and ops; wake alone brings the core back
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         power_down_q <= 1'h0;
      else if (sleep_in)
         power_down_q <= 1'h1;
      else if (wake_in)
         power_down_q <= 1'h0;
   end
   assign power_down_out = power_down_q;

   // ============================================================
   // checks
   // ============================================================
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   // $past has no history on the first edge out of a reset, so checks on it wait one edge
   logic past_ok_q;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         past_ok_q <= 1'h0;
      else
         past_ok_q <= 1'h1;
   end

   sequence s_vec_taken;
      fetch_take && vec_req_in;
   endsequence

   sequence s_div_word_start;
      op_take && (op_kind_in == addr_mode_pkg::OP_DIV_W);
   endsequence

   mode_adv_only_a: assert property (mode_taken_q |-> adv_mode_out)
      else $error("core left advanced addressing mode");

   ea_truncate_a: assert property (ea_valid_in |=> ea_phys_out[31:24] == 8'h00 &&
                                   ea_phys_out[23:0] == $past(ea_in[23:0]))
      else $error("effective address not truncated to 24 bits");

   vec_addr_a: assert property (s_vec_taken |=> mem_rd_out && mem_long_out &&
                                mem_addr_out == 32'({$past(vec_num_in), 2'h0}))
      else $error("vector fetch address or size wrong");

   ind_range_a: assert property (fetch_take && !vec_req_in |=> mem_rd_out &&
                                 mem_addr_out <= addr_mode_pkg::IND_LIMIT &&
                                 mem_addr_out == 32'($past(ind_abs_in)))
      else $error("indirect operand outside low 256 bytes");

   target_top_zero_a: assert property (mem_rd_out && mem_ack_in |=> target_valid_out &&
                                       target_out[31:24] == 8'h00)
      else $error("target top byte not zero");

   push_mode0_a: assert property (push_req_in && push_exc_in && int_mode0_in |=>
                                  push_items_out == 3'h3)
      else $error("extended control pushed in mode 0");

   push_call_a: assert property (push_req_in && !push_exc_in |=> push_items_out == 3'h1)
      else $error("call must push only the counter");

   add_one_a: assert property (op_take && op_kind_in == addr_mode_pkg::OP_ADD |=>
                               op_done_out ##1 !op_busy_out)
      else $error("add not done in one state");

   mulu_byte_a: assert property (op_take && op_kind_in == addr_mode_pkg::OP_MULU_B |=>
                                 !op_done_out [*2] ##1 op_done_out)
      else $error("unsigned byte multiply not three states");

   div_word_a: assert property (s_div_word_start |-> ##20 op_done_out ##1 !op_busy_out)
      else $error("word divide not twenty states");

   sleep_hold_a: assert property (sleep_in |=> power_down_out && !fetch_ready_out)
      else $error("sleep did not enter power-down");

   fetch_even_a: assert property (past_ok_q |-> fetch_addr_out[0] == 1'h0 &&
                                  fetch_addr_out[23:1] == $past(pc_in[23:1]))
      else $error("fetch address not word aligned");

   carry_upper_a: assert property (incdec_in |=> {upper_out, lower_out} ==
                                   ($past(dec_in) ? $past({upper_in, lower_in}) - 32'($past(step_in))
                                                  : $past({upper_in, lower_in}) + 32'($past(step_in))))
      else $error("carry not propagated into upper half");

endmodule : cpu_address_mode_logic
`default_nettype wire

// ---- test/mem_model.sv ----
// partner memory on the internal bus: answers reads with a one-cycle ack
// assumes the requester holds rd and addr until the ack cycle
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        rd_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [1:0]  lat_in,
   output logic             ack_out,
   output logic [31:0]      rdata_out
);
   logic [1:0]  wait_q;
   logic [31:0] junk_q;
   // ===========================================
   // answer timing
   // ===========================================
   // ack after lat_in extra cycles; never two acks back to back
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ack_out <= 1'b0;
         wait_q  <= 2'h0;
      end
      else if (rd_in && !ack_out && wait_q == lat_in)
      begin
         ack_out <= 1'b1;
         wait_q  <= 2'h0;
      end
      else
      begin
         ack_out <= 1'b0;
         wait_q  <= (rd_in && !ack_out) ? wait_q + 2'h1 : 2'h0;
      end
   end
   // data is valid only with ack; otherwise a pattern that changes every
   // cycle, so a stale capture cannot pass by luck
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         junk_q <= 32'h0;
      else
         junk_q <= junk_q + 32'h9E3779B9;
   end
   assign rdata_out = ack_out ? {~addr_in[7:0], addr_in[7:0] ^ 8'h3C, addr_in[15:0]} : junk_q;
endmodule : mem_model
`default_nettype wire

// ---- test/cpu_address_mode_logic_tb.sv ----
// self-checking bench of the address-mode unit with the memory partner
// assumes one 250 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
   $display("BAD %s exp %0h got %0h", what, exp, got); end end
module cpu_address_mode_logic_tb;
   logic clk_in = 1'b0, rst_n_in = 1'b0;
   logic [2:0] mode_pins_in = 3'h1, step_in = 3'h1, op_kind_in = 3'h0;
   logic ea_valid_in = 1'b0, vec_req_in = 1'b0, ind_req_in = 1'b0, push_req_in = 1'b0;
   logic push_exc_in = 1'b0, int_mode0_in = 1'b0, incdec_in = 1'b0, dec_in = 1'b0;
   logic op_start_in = 1'b0, sleep_in = 1'b0, wake_in = 1'b0, mem_ack_in;
   logic [31:0] ea_in = 32'h0, mem_rdata_in, ea_phys_out, mem_addr_out, target_out;
   logic [23:0] pc_in = 24'h0, fetch_addr_out;
   logic [7:0]  vec_num_in = 8'h0, ind_abs_in = 8'h0;
   logic [15:0] upper_in = 16'h0, lower_in = 16'h0, upper_out, lower_out;
   logic [1:0]  lat = 2'h0;
   logic [2:0]  push_items_out, pe;
   logic [31:0] pr;
   logic adv_mode_out, mode_fault_out, fetch_ready_out, mem_rd_out, mem_long_out;
   logic target_valid_out, op_busy_out, op_done_out, power_down_out;
   int errors = 0, cmp_count = 0, i, n, dn;
   int n_tab[8] = '{1, 3, 4, 4, 5, 12, 20, 1};

   cpu_address_mode_logic u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .mode_pins_in(mode_pins_in),
      .adv_mode_out(adv_mode_out), .mode_fault_out(mode_fault_out), .ea_valid_in(ea_valid_in),
      .ea_in(ea_in), .ea_phys_out(ea_phys_out), .pc_in(pc_in), .fetch_addr_out(fetch_addr_out),
      .vec_req_in(vec_req_in), .vec_num_in(vec_num_in), .ind_req_in(ind_req_in), .ind_abs_in(ind_abs_in),
      .fetch_ready_out(fetch_ready_out), .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
      .mem_long_out(mem_long_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
      .target_valid_out(target_valid_out), .target_out(target_out), .push_req_in(push_req_in),
      .push_exc_in(push_exc_in), .int_mode0_in(int_mode0_in), .push_items_out(push_items_out),
      .incdec_in(incdec_in), .dec_in(dec_in), .step_in(step_in), .upper_in(upper_in), .lower_in(lower_in),
      .upper_out(upper_out), .lower_out(lower_out), .op_start_in(op_start_in), .op_kind_in(op_kind_in),
      .op_busy_out(op_busy_out), .op_done_out(op_done_out), .sleep_in(sleep_in), .wake_in(wake_in),
      .power_down_out(power_down_out));
   mem_model u_mem (.clk_in(clk_in), .rst_n_in(rst_n_in), .rd_in(mem_rd_out), .addr_in(mem_addr_out),
      .lat_in(lat), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

   // ===========================================
   // clock, verdict, watchdog
   // ===========================================
   always #2 clk_in = ~clk_in;
   task end_of_test;
      $display("checks %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // the whole run needs about 200 cycles; allow far more
   initial
   begin
      #100000;
      errors++;
      end_of_test();
   end

   // ===========================================
   // shared tasks
   // ===========================================
   // reset with a given pin code; mode is taken at the first edge after release
   task automatic do_reset(input logic [2:0] pins);
      rst_n_in = 1'b0;
      mode_pins_in = pins;
      repeat (6) @(negedge clk_in);
      `CHK("adv_rst", 1'b1, adv_mode_out)
      `CHK("ready_rst", 1'b1, fetch_ready_out)
      rst_n_in = 1'b1;
      repeat (2) @(negedge clk_in);
      mode_pins_in = ~pins; // later pin changes must be ignored
      @(negedge clk_in);
      `CHK("fault", pins == 3'h1, mode_fault_out)
      `CHK("adv", 1'b1, adv_mode_out)
   endtask : do_reset
   // vector (v=1) or memory-indirect branch operand fetch at random latency
   task automatic fetch(input logic v, input logic [7:0] num);
      logic [31:0] a;
      int k;
      a = v ? {22'h0, num, 2'h0} : {24'h0, num};
      lat = 2'($urandom_range(0, 3));
      vec_req_in = v;
      ind_req_in = 1'b1; // also raised with a vector to check its priority
      vec_num_in = num;
      ind_abs_in = ~num;
      if (!v)
         ind_abs_in = num;
      @(negedge clk_in);
      vec_req_in = 1'b0;
      ind_req_in = 1'b0;
      `CHK("rd", 1'b1, mem_rd_out)
      `CHK("addr", a, mem_addr_out)
      `CHK("long", 1'b1, mem_long_out)
      k = 0;
      while (target_valid_out !== 1'b1 && k < 20)
      begin
         @(negedge clk_in);
         k++;
      end
      `CHK("tv", 1'b1, target_valid_out)
      `CHK("target", {8'h00, a[7:0] ^ 8'h3C, a[15:0]}, target_out)
      @(negedge clk_in);
      `CHK("tv_pulse", 1'b0, target_valid_out)
   endtask : fetch

   // ===========================================
   // main sequence
   // ===========================================
   initial
   begin
      void'($urandom(2));
      do_reset(3'h1);
      // address truncation and fetch alignment, back to back
      for (i = 0; i < 30; i++)
      begin
         ea_valid_in = 1'b1;
         ea_in = $urandom;
         pc_in = 24'($urandom);
         @(negedge clk_in);
         `CHK("ea", ea_in & 32'h00FFFFFF, ea_phys_out)
         `CHK("pc", pc_in & 24'hFFFFFE, fetch_addr_out)
      end
      ea_valid_in = 1'b0;
      // table edges first, then random entries
      fetch(1'b1, 8'h00);
      fetch(1'b1, 8'hFF);
      fetch(1'b0, 8'hFF);
      for (i = 0; i < 8; i++)
         fetch(1'($urandom_range(0, 1)), 8'($urandom));
      // stack push sets, held high for back-to-back requests
      for (i = 0; i < 4; i++)
      begin
         push_req_in = 1'b1;
         push_exc_in = i[1];
         int_mode0_in = i[0];
         pe = !i[1] ? 3'h1 : (i[0] ? 3'h3 : 3'h7);
         @(negedge clk_in);
         `CHK("push", pe, push_items_out)
      end
      push_req_in = 1'b0;
      @(negedge clk_in);
      `CHK("push_end", 3'h0, push_items_out)
      // register pair step, carry and borrow across the halves first
      for (i = 0; i < 20; i++)
      begin
         pr = $urandom;
         step_in = 3'(1 << $urandom_range(0, 2));
         dec_in = 1'($urandom_range(0, 1));
         if (i < 2)
         begin
            pr = i ? 32'h00050000 : 32'h0001FFFF;
            dec_in = i[0];
            step_in = 3'h1;
         end
         {upper_in, lower_in} = pr;
         incdec_in = 1'b1;
         @(negedge clk_in);
         pr = dec_in ? pr - step_in : pr + step_in;
         `CHK("pair", pr, {upper_out, lower_out})
      end
      incdec_in = 1'b0;
      // execution states of every op kind, next start right after the last
      for (i = 0; i < 8; i++)
      begin
         op_kind_in = 3'(i);
         op_start_in = 1'b1;
         @(negedge clk_in);
         op_start_in = 1'b0;
         n = 0;
         dn = 0;
         while (op_busy_out === 1'b1 && n < 40)
         begin
            n++;
            if (op_done_out === 1'b1)
               dn = n;
            @(negedge clk_in);
         end
         `CHK("busy_n", n_tab[i], n)
         `CHK("done_n", n_tab[i], dn)
      end
      // power-down: sleep beats wake, no fetch or op is taken meanwhile
      sleep_in = 1'b1;
      wake_in = 1'b1;
      @(negedge clk_in);
      sleep_in = 1'b0;
      wake_in = 1'b0;
      `CHK("pd", 1'b1, power_down_out)
      `CHK("pd_ready", 1'b0, fetch_ready_out)
      op_start_in = 1'b1;
      vec_req_in = 1'b1;
      @(negedge clk_in);
      op_start_in = 1'b0;
      vec_req_in = 1'b0;
      `CHK("pd_busy", 1'b0, op_busy_out)
      `CHK("pd_rd", 1'b0, mem_rd_out)
      wake_in = 1'b1;
      @(negedge clk_in);
      wake_in = 1'b0;
      `CHK("wake", 1'b0, power_down_out)
      // second reset with an advanced pin code, then traffic again
      do_reset(3'h4);
      fetch(1'b1, 8'h03);
      end_of_test();
   end
endmodule : cpu_address_mode_logic_tb
`default_nettype wire
